// File: hw/kwd_params.svh
// offsets, field positions, reset values and timing counts for the keyed watchdog
`ifndef KWD_PARAMS_SVH
`define KWD_PARAMS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define KWD_OFS_RELOAD      12'h000
`define KWD_OFS_COUNT       12'h004
`define KWD_OFS_CONTROL     12'h008
`define KWD_OFS_REFRESH     12'h00c
`define KWD_OFS_STATUS      12'h018

// ----------------------------------------------------------------------------
// control fields
// ----------------------------------------------------------------------------
`define KWD_CTL_STYLE       6
`define KWD_CTL_ENABLE      5
`define KWD_CTL_PRE_HI      3
`define KWD_CTL_PRE_LO      2
`define KWD_CTL_ACTION      1
`define KWD_CTL_SLEEP       0
`define KWD_CTL_WMASK       16'h006f

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define KWD_STA_LOCK        4
`define KWD_STA_CTL_BUSY    3
`define KWD_STA_LD_BUSY     2
`define KWD_STA_REF_BUSY    1
`define KWD_STA_PENDING     0

// ----------------------------------------------------------------------------
// reset values, key and counts
// ----------------------------------------------------------------------------
`define KWD_RST_RELOAD      16'h1000
`define KWD_RST_CONTROL     16'h00e9
`define KWD_FREE_START      16'h1000
`define KWD_REFRESH_KEY     16'hcccc
`define KWD_LF_HZ           32768
`define KWD_DEFAULT_SEC     32
`define KWD_DIV1_LIM        12'h000
`define KWD_DIV16_LIM       12'h00f
`define KWD_DIV256_LIM      12'h0ff
`define KWD_DIV4096_LIM     12'hfff

`endif

// File: hw/kwd_pkg.sv
// types shared by the keyed watchdog
package kwd_pkg;

    // ------------------------------------------------------------------------
    // bus phase, one-hot
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        KWD_IDLE = 2'b01,
        KWD_ACK  = 2'b10
    } kwd_phase_t;

    // ------------------------------------------------------------------------
    // whole state of the watchdog
    // ------------------------------------------------------------------------
    typedef struct packed {
        kwd_phase_t  phase;
        logic [31:0] prdata;
        logic        pslverr;
        logic        lf_s1;
        logic        lf_s2;
        logic        lf_s3;
        logic        lf_lvl;
        logic [11:0] pre_cnt;
        logic [15:0] count;
        logic [15:0] reload_sw;
        logic [15:0] reload_act;
        logic [15:0] ctl_sw;
        logic [15:0] ctl_act;
        logic        key_good;
        logic        ctl_busy;
        logic        ld_busy;
        logic        ref_busy;
        logic        locked;
        logic        pending;
        logic        sys_rst;
        logic        sleep_q;
    } kwd_state_t;

endpackage

// File: hw/kwd_watchdog.sv
// keyed watchdog timer with apb register access
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

`include "kwd_params.svh"

// How it works
// - watchdog comes up enabled after every reset
// - writing enable one locks control and reload
// - lock reads zero until enable is written
// - clear enable stops; re-enable only once
// - reload writable anytime while control unlocked
// - free style counts from 0x1000, ignores reload
// - periodic style starts each period from reload
// - prescaler divides by 1, 16, 256, 4096
// - zero count gives reset or interrupt
// - interrupt choice only outside power-down
// - key write reloads counter and restarts period
// - key write clears pending interrupt
// - wrong key fires the timeout action
// - refresh register write-only, reads zero
// - sleep bit picks continue or restart after sleep
// - counter runs from low-frequency clock always
// - control busy until write reaches timer side
// - reload and refresh busy until synchronised
// - current count register returns counter value
// - status bit zero shows pending interrupt
// - reset defaults give about 32 second period
module kwd_watchdog
    import kwd_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // low-frequency oscillator pin
    input  wire logic        low_freq_oscillator,
    // power-down mode of the chip
    input  wire logic        sleep_mode,
    // timeout actions
    output logic             sys_reset_req,
    output logic             timeout_pending
);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [11:0] pre_limit(input logic [1:0] sel);
        logic [11:0] lim;
        case (sel)
            2'b00:   lim = `KWD_DIV1_LIM;
            2'b01:   lim = `KWD_DIV16_LIM;
            2'b10:   lim = `KWD_DIV256_LIM;
            default: lim = `KWD_DIV4096_LIM;
        endcase
        return lim;
    endfunction

    function automatic logic [15:0] start_value(input logic [15:0] ctl,
                                               input logic [15:0] rld);
        logic [15:0] v;
        if (ctl[`KWD_CTL_STYLE]) begin
            v = rld;
        end else begin
            v = `KWD_FREE_START;
        end
        return v;
    endfunction

    // returns {reset, interrupt}
    function automatic logic [1:0] fire(input logic [15:0] ctl,
                                        input logic        sleeping);
        logic [1:0] f;
        // in power-down the interrupt is not offered, so a reset is forced
        if (ctl[`KWD_CTL_ACTION] && !sleeping) begin
            f = 2'b01;
        end else begin
            f = 2'b10;
        end
        return f;
    endfunction

    function automatic logic addr_is(input logic [11:0] a,
                                     input logic [11:0] ofs);
        return a[11:2] == ofs[11:2];
    endfunction

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    kwd_state_t s_q;
    kwd_state_t s_d;

    logic        lf_rise;
    logic        tick;
    logic        refreshed;
    logic        wr_done;
    logic        mapped;
    logic [31:0] rd_val;
    logic [1:0]  act;
    logic [11:0] lim;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_d       = s_q;
        s_d.sys_rst = 1'b0;
        lf_rise   = 1'b0;
        tick      = 1'b0;
        refreshed = 1'b0;
        act       = 2'b00;
        lim       = pre_limit(s_q.ctl_act[`KWD_CTL_PRE_HI:`KWD_CTL_PRE_LO]);

        // oscillator pin: three stages, a change counts once stages 2 and 3 agree
        s_d.lf_s1 = low_freq_oscillator;
        s_d.lf_s2 = s_q.lf_s1;
        s_d.lf_s3 = s_q.lf_s2;
        if (s_q.lf_s2 == s_q.lf_s3 && s_q.lf_s3 != s_q.lf_lvl) begin
            s_d.lf_lvl = s_q.lf_s3;
            lf_rise    = s_q.lf_s3;
        end

        // timer side: every rising oscillator edge first takes over pending writes
        if (lf_rise) begin
            if (s_q.ctl_busy) begin
                s_d.ctl_act  = s_q.ctl_sw;
                s_d.ctl_busy = 1'b0;
            end
            if (s_q.ld_busy) begin
                s_d.reload_act = s_q.reload_sw;
                s_d.ld_busy    = 1'b0;
            end
            if (s_q.ref_busy) begin
                s_d.ref_busy = 1'b0;
                if (s_q.key_good) begin
                    s_d.pending = 1'b0;
                    s_d.count   = start_value(s_d.ctl_act, s_d.reload_act);
                    s_d.pre_cnt = 12'h000;
                    refreshed   = 1'b1;
                end else begin
                    act = fire(s_d.ctl_act, sleep_mode);
                end
            end
            // counting runs on the oscillator whenever enabled
            if (s_d.ctl_act[`KWD_CTL_ENABLE] && !refreshed) begin
                if (s_q.pre_cnt >= lim) begin
                    s_d.pre_cnt = 12'h000;
                    tick        = 1'b1;
                end else begin
                    s_d.pre_cnt = s_q.pre_cnt + 12'h001;
                end
            end
            if (tick) begin
                // a zero reload also times out on the first tick
                if (s_q.count <= 16'h0001) begin
                    act     = act | fire(s_d.ctl_act, sleep_mode);
                    s_d.count = start_value(s_d.ctl_act, s_d.reload_act);
                end else begin
                    s_d.count = s_q.count - 16'h0001;
                end
            end
        end

        // leaving power-down may restart the period
        s_d.sleep_q = sleep_mode;
        if (s_q.sleep_q && !sleep_mode && s_d.ctl_act[`KWD_CTL_SLEEP]) begin
            s_d.count   = start_value(s_d.ctl_act, s_d.reload_act);
            s_d.pre_cnt = 12'h000;
        end

        if (act[1]) begin
            s_d.sys_rst = 1'b1;
        end
        if (act[0]) begin
            s_d.pending = 1'b1;
        end

        // bus side: read data is captured in the first access cycle
        mapped = addr_is(paddr, `KWD_OFS_RELOAD) || addr_is(paddr, `KWD_OFS_COUNT) ||
                 addr_is(paddr, `KWD_OFS_CONTROL) || addr_is(paddr, `KWD_OFS_REFRESH) ||
                 addr_is(paddr, `KWD_OFS_STATUS);
        rd_val = 32'h0000_0000;
        if (addr_is(paddr, `KWD_OFS_RELOAD)) begin
            rd_val = {16'h0000, s_q.reload_sw};
        end else if (addr_is(paddr, `KWD_OFS_COUNT)) begin
            rd_val = {16'h0000, s_q.count};
        end else if (addr_is(paddr, `KWD_OFS_CONTROL)) begin
            rd_val = {16'h0000, s_q.ctl_sw};
        end else if (addr_is(paddr, `KWD_OFS_STATUS)) begin
            rd_val[`KWD_STA_LOCK]     = s_q.locked;
            rd_val[`KWD_STA_CTL_BUSY] = s_q.ctl_busy;
            rd_val[`KWD_STA_LD_BUSY]  = s_q.ld_busy;
            rd_val[`KWD_STA_REF_BUSY] = s_q.ref_busy;
            rd_val[`KWD_STA_PENDING]  = s_q.pending;
        end

        wr_done = 1'b0;
        case (s_q.phase)
            KWD_IDLE: begin
                if (psel && penable) begin
                    s_d.phase   = KWD_ACK;
                    s_d.prdata  = pwrite ? 32'h0000_0000 : rd_val;
                    s_d.pslverr = !mapped;
                end
            end
            KWD_ACK: begin
                // the write lands on the edge that completes the transfer
                wr_done     = psel && penable && pwrite;
                s_d.phase   = KWD_IDLE;
                s_d.prdata  = 32'h0000_0000;
                s_d.pslverr = 1'b0;
            end
            default: begin
                s_d.phase   = KWD_IDLE;
                s_d.prdata  = 32'h0000_0000;
                s_d.pslverr = 1'b0;
            end
        endcase

        // a new write marks busy after any take-over above, so set wins
        if (wr_done && !s_q.locked) begin
            if (addr_is(paddr, `KWD_OFS_CONTROL)) begin
                // reserved bits are dropped; enable may be cleared once
                s_d.ctl_sw   = pwdata[15:0] & `KWD_CTL_WMASK;
                s_d.ctl_busy = 1'b1;
                if (pwdata[`KWD_CTL_ENABLE]) begin
                    s_d.locked = 1'b1;
                end
            end
            if (addr_is(paddr, `KWD_OFS_RELOAD)) begin
                s_d.reload_sw = pwdata[15:0];
                s_d.ld_busy   = 1'b1;
            end
        end
        if (wr_done && addr_is(paddr, `KWD_OFS_REFRESH)) begin
            s_d.key_good = pwdata[15:0] == `KWD_REFRESH_KEY;
            s_d.ref_busy = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s_q            <= '0;
            s_q.phase      <= KWD_IDLE;
            s_q.count      <= `KWD_RST_RELOAD;
            s_q.reload_sw  <= `KWD_RST_RELOAD;
            s_q.reload_act <= `KWD_RST_RELOAD;
            s_q.ctl_sw     <= `KWD_RST_CONTROL;
            s_q.ctl_act    <= `KWD_RST_CONTROL;
            s_q.locked     <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign prdata          = s_q.prdata;
    assign pready          = s_q.phase == KWD_ACK;
    assign pslverr         = s_q.pslverr;
    assign sys_reset_req   = s_q.sys_rst;
    assign timeout_pending = s_q.pending;

endmodule // kwd_watchdog

// File: tb/kwd_watchdog_props.sv
// port assertions for the keyed watchdog
`timescale 1ns/1ps
module kwd_watchdog_props (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        rstn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // timer side
    input wire logic        low_freq_oscillator,
    input wire logic        sleep_mode,
    input wire logic        sys_reset_req,
    input wire logic        timeout_pending
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic       mapped;
    logic       ref_wr;
    logic [7:0] since_q;
    assign mapped = paddr[11:2] inside {10'h0, 10'h1, 10'h2, 10'h3, 10'h6};
    assign ref_wr = pready && pwrite && paddr[11:2] == 10'h3;
    // cycles since the last refresh commit, saturating
    always_ff @(posedge core_clk) begin
        if (!rstn || ref_wr) begin
            since_q <= 8'h00;
        end else if (since_q != 8'hff) begin
            since_q <= since_q + 8'h01;
        end
    end
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    sequence s_done;
        pready ##1 !pready;
    endsequence
    a_one_wait: assert property (s_wait |=> s_done) else $error("ready not after one wait");
    a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray ready");
    a_err_map: assert property (pready |-> pslverr == !mapped) else $error("error flag wrong");
    a_idle_quiet: assert property (!pready |-> !pslverr && prdata == 32'h0)
        else $error("bus outputs not quiet");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper bits set");
    a_refresh_wo: assert property (pready && !pwrite && paddr[11:2] == 10'h3 |-> prdata == 32'h0)
        else $error("refresh read not zero");
    a_reset_pulse: assert property ($rose(sys_reset_req) |=> !sys_reset_req)
        else $error("reset demand too long");
    a_pend_clear: assert property ($fell(timeout_pending) |-> since_q < 8'd60)
        else $error("pending dropped without refresh");
endmodule // kwd_watchdog_props

bind kwd_watchdog kwd_watchdog_props u_props (.core_clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .low_freq_oscillator, .sleep_mode,
    .sys_reset_req, .timeout_pending);

// File: tb/kwd_sys_partner.sv
// stand-in for the oscillator and reset controller
`timescale 1ns/1ps
module kwd_sys_partner (
    // watchdog side
    input  wire logic core_clk,
    input  wire logic osc_hold,
    input  wire logic sys_reset_req,
    input  wire logic timeout_pending,
    output logic      low_freq_oscillator,
    output logic      sys_rst_n,
    output int        reset_cnt
);
    int hold = 0;
    // phase unrelated to core_clk; hold only freezes it to make sync states visible
    initial begin
        low_freq_oscillator = 1'b0;
        sys_rst_n = 1'b1;
        reset_cnt = 0;
        forever begin
            #83;
            if (!osc_hold) low_freq_oscillator = ~low_freq_oscillator;
        end
    end
    // a demand keeps the chip in reset a few cycles, as a real controller would
    always @(posedge core_clk) begin
        if (sys_reset_req === 1'b1) begin
            reset_cnt <= reset_cnt + 1;
            hold <= 4;
        end else if (hold > 0) begin
            hold <= hold - 1;
        end
        sys_rst_n <= !(sys_reset_req === 1'b1 || hold > 1);
    end
endmodule // kwd_sys_partner

// File: tb/tb_keyed_watchdog_timer.sv
// self-checking bench for the keyed watchdog
`timescale 1ns/1ps
`include "kwd_params.svh"
module tb_keyed_watchdog_timer;
    logic        core_clk, tb_rst_n, rstn, psel, penable, pwrite, sleep_mode, osc_hold;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, bad;
    logic        pready, pslverr, er, lfo, sys_reset_req, timeout_pending, sys_rst_n;
    int          error_cnt = 0, cmp_count = 0, cycles = 0, resets, m_rld, m_ctl;
    assign rstn = tb_rst_n & sys_rst_n;
    kwd_watchdog dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .low_freq_oscillator(lfo), .sleep_mode, .sys_reset_req,
        .timeout_pending);
    kwd_sys_partner u_sys (.core_clk, .osc_hold, .sys_reset_req, .timeout_pending,
        .low_freq_oscillator(lfo), .sys_rst_n, .reset_cnt(resets));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            results();
        end
    end
    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input string n, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask
    task automatic settle;
        do apb(1'b0, `KWD_OFS_STATUS, 32'h0); while (rd[3:1] !== 3'b000);
    endtask
    initial begin
        void'($urandom(32'h0cf7));
        {tb_rst_n, psel, penable, pwrite, sleep_mode, osc_hold} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (16) @(posedge core_clk);
        tb_rst_n <= 1'b1;
        m_rld = 32'h1000;
        m_ctl = 32'he9;
        rdchk(`KWD_OFS_RELOAD, "reload", m_rld);
        rdchk(`KWD_OFS_COUNT, "count", 32'h1000);
        rdchk(`KWD_OFS_CONTROL, "control", m_ctl);
        rdchk(`KWD_OFS_REFRESH, "refresh", 32'h0);
        rdchk(`KWD_OFS_STATUS, "status", 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", er, 1);
        // frozen oscillator keeps every write waiting in the sync stage
        osc_hold <= 1'b1;
        m_rld = 16 + $urandom_range(16);
        apb(1'b1, `KWD_OFS_CONTROL, 32'h0);
        apb(1'b1, `KWD_OFS_RELOAD, m_rld);
        apb(1'b1, `KWD_OFS_REFRESH, `KWD_REFRESH_KEY);
        rdchk(`KWD_OFS_STATUS, "sync busy", 32'he);
        osc_hold <= 1'b0;
        settle();
        m_ctl = 32'h63;
        apb(1'b1, `KWD_OFS_CONTROL, m_ctl);
        settle();
        chk("lock", rd[4], 1);
        apb(1'b1, `KWD_OFS_RELOAD, 32'h7);
        apb(1'b1, `KWD_OFS_CONTROL, 32'h0);
        settle();
        rdchk(`KWD_OFS_RELOAD, "locked reload", m_rld);
        rdchk(`KWD_OFS_CONTROL, "locked control", m_ctl);
        // the earlier refresh ran in free style; restart the period from reload now
        apb(1'b1, `KWD_OFS_REFRESH, `KWD_REFRESH_KEY);
        settle();
        apb(1'b0, `KWD_OFS_COUNT, 32'h0);
        chk("count in period", rd <= m_rld, 1);
        while (timeout_pending !== 1'b1) @(posedge core_clk);
        rdchk(`KWD_OFS_STATUS, "pending", 32'h11);
        chk("no reset", resets, 0);
        apb(1'b1, `KWD_OFS_REFRESH, `KWD_REFRESH_KEY);
        settle();
        chk("cleared", timeout_pending, 0);
        apb(1'b0, `KWD_OFS_COUNT, 32'h0);
        chk("reloaded", rd <= m_rld && rd + 4 >= m_rld, 1);
        bad = $urandom_range(32'hcccb);
        apb(1'b1, `KWD_OFS_REFRESH, bad);
        settle();
        chk("bad key irq", timeout_pending, 1);
        // in power-down the interrupt choice is void, so a reset must follow
        sleep_mode <= 1'b1;
        apb(1'b1, `KWD_OFS_REFRESH, bad);
        while (resets == 0) @(posedge core_clk);
        sleep_mode <= 1'b0;
        repeat (10) @(posedge core_clk);
        chk("reset demanded", resets, 1);
        rdchk(`KWD_OFS_CONTROL, "control after reset", 32'he9);
        rdchk(`KWD_OFS_STATUS, "status after reset", 32'h0);
        apb(1'b1, `KWD_OFS_RELOAD, 32'h5);
        rdchk(`KWD_OFS_RELOAD, "reload open", 32'h5);
        apb(1'b1, `KWD_OFS_CONTROL, 32'h21);
        settle();
        apb(1'b1, `KWD_OFS_REFRESH, `KWD_REFRESH_KEY);
        settle();
        apb(1'b0, `KWD_OFS_COUNT, 32'h0);
        chk("free start", rd <= 32'h1000 && rd > 32'hfe0, 1);
        results();
    end
endmodule // tb_keyed_watchdog_timer
